/* design/input_command_decoder.sv */
// Command item decoder: fieldbus and digital input commands to job actions
`timescale 1ns/10ps
`default_nettype none
`include "cmd_decoder_consts.svh"
module input_command_decoder
	import cmd_decoder_pkg::*;
#(
	parameter int BATCH_W = 8,
	parameter int ID_W = 4,
	parameter int RES_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Command items from the fieldbus master and from digital inputs
	input wire cmd_items_s fb_cmd,
	input wire logic [7:0] fb_abort_char,
	input wire cmd_items_s di_cmd,
	// Tightening side events
	input wire logic [RES_W-1:0] result_set,
	input wire logic id_accept,
	// Actions and state
	output job_state_e job_state,
	output logic [BATCH_W-1:0] batch_count,
	output logic batch_ok,
	output logic xml_send_hold,
	output logic [RES_W-1:0] result_status,
	output logic [ID_W-1:0] id_expect
);
	// Pulses after edge detection
	logic [10:0] lvl;
	logic [10:0] rise;
	logic char_is_a;
	logic abort_p, abort_stat_p, inc_p, bypass_p, dec_fb_p, dec_di_p;
	logic dec_ok;
	logic batch_done;
	// Registers
	job_state_e job_q, job_d;
	logic ref_di_q, ref_di_d;
	logic policy_q, policy_d;
	logic [BATCH_W-1:0] size_q, size_d;
	logic ok_q, ok_d;
	logic xml_q, xml_d;
	logic [RES_W-1:0] res_q, res_d;
	logic [ID_W-1:0] idp_q, idp_d;
	logic [ID_W-1:0] wo_len_q, wo_len_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic start;
	logic req, wr_take, rd_take;

	// Character form of abort is a level: true while it holds the letter
	assign char_is_a = (fb_abort_char == `ABORT_LETTER);
	assign lvl = {char_is_a, fb_cmd.abort, fb_cmd.abort_stat, fb_cmd.batch_dec,
		fb_cmd.batch_inc, fb_cmd.id_bypass, di_cmd.abort, di_cmd.abort_stat,
		di_cmd.batch_dec, di_cmd.batch_inc, di_cmd.id_bypass};

	// One action per rise of each item except xml_hold, never per held cycle
	rise_detect #(.W(11)) u_rise (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.level(lvl),
		.rise(rise)
	);

	// Merge sources; a set condition raises, reset merely clears the level
	assign abort_p = rise[10] | rise[9] | rise[4];
	assign abort_stat_p = rise[8] | rise[3];
	assign dec_fb_p = rise[7];
	assign dec_di_p = rise[2];
	assign inc_p = rise[6] | rise[1];
	assign bypass_p = rise[5] | rise[0];

	// Decrement gating: only from the reference while running, none when done
	always_comb begin
		case (job_q)
			JOB_RUN: dec_ok = ref_di_q ? dec_di_p : dec_fb_p;
			JOB_DONE: dec_ok = 1'b0;
			default: dec_ok = dec_fb_p | dec_di_p;
		endcase
	end

	// Batch counter, cleared when a job starts
	batch_counter #(.W(BATCH_W)) u_batch (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clear(start),
		.inc(inc_p && job_q != JOB_DONE),
		.dec(dec_ok),
		.size(size_q),
		.count_q(batch_count),
		.done(batch_done)
	);

	// Bus handshake: one wait state, request held by the master
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_take = avs_write & ack_q;
	assign rd_take = avs_read & ~ack_q;
	assign start = wr_take && avs_address == `REG_CTRL &&
		avs_writedata[`CTRL_START];

	// Job state code for readback
	function automatic logic [1:0] job_code(input job_state_e s);
		case (s)
			JOB_IDLE: job_code = 2'h0;
			JOB_RUN: job_code = 2'h1;
			JOB_DONE: job_code = 2'h2;
			default: job_code = 2'h3;
		endcase
	endfunction

	// Next state of job, configuration, results and bus
	always_comb begin
		job_d = job_q;
		ref_di_d = ref_di_q;
		policy_d = policy_q;
		size_d = size_q;
		ok_d = ok_q;
		xml_d = fb_cmd.xml_hold | di_cmd.xml_hold;
		res_d = res_q;
		idp_d = idp_q;
		wo_len_d = wo_len_q;
		ack_d = req & ~ack_q;
		rdata_d = rdata_q;
		// Job progress and aborts
		if (start) begin
			job_d = JOB_RUN;
		end else if ((abort_p || abort_stat_p) && job_q == JOB_RUN) begin
			job_d = JOB_ABORTED;
		end else if (job_q == JOB_RUN && batch_done) begin
			job_d = JOB_DONE;
		end
		// Batch status after an increment follows the policy
		if (start) begin
			ok_d = 1'b0;
		end else if (inc_p && job_q != JOB_DONE) begin
			ok_d = policy_q;
		end
		// Result status: clear by command, new results win over the clear
		if (abort_stat_p) begin
			res_d = '0;
		end
		res_d = res_d | result_set;
		// Identifier position: accept or bypass moves to the next type
		if (bypass_p || id_accept) begin
			if (idp_q + ID_W'(1) >= wo_len_q) begin
				idp_d = '0;
			end else begin
				idp_d = idp_q + ID_W'(1);
			end
		end
		// Register writes
		if (wr_take) begin
			case (avs_address)
				`REG_CTRL: begin
					ref_di_d = avs_writedata[`CTRL_REF_DI];
					policy_d = avs_writedata[`CTRL_POLICY];
				end
				`REG_BATCH: size_d = avs_writedata[`BATCH_SIZE_LSB +: BATCH_W];
				`REG_IDENT: wo_len_d = avs_writedata[`IDENT_LEN_LSB +: ID_W];
				default: ;
			endcase
		end
		// Register reads, unmapped reads give zero
		if (rd_take) begin
			rdata_d = '0;
			case (avs_address)
				`REG_CTRL: begin
					rdata_d[`CTRL_REF_DI] = ref_di_q;
					rdata_d[`CTRL_POLICY] = policy_q;
				end
				`REG_STATUS: rdata_d = {29'h0, xml_q, job_code(job_q)};
				`REG_BATCH: begin
					rdata_d[BATCH_W-1:0] = batch_count;
					rdata_d[`BATCH_SIZE_LSB +: BATCH_W] = size_q;
					rdata_d[`BATCH_OK_BIT] = ok_q;
				end
				`REG_RESULT: rdata_d[RES_W-1:0] = res_q;
				`REG_IDENT: begin
					rdata_d[ID_W-1:0] = idp_q;
					rdata_d[`IDENT_LEN_LSB +: ID_W] = wo_len_q;
				end
				default: ;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			job_q <= JOB_IDLE;
			ref_di_q <= 1'b0;
			policy_q <= 1'b0;
			size_q <= `RST_BATCH_SIZE;
			ok_q <= 1'b0;
			xml_q <= 1'b0;
			res_q <= '0;
			idp_q <= '0;
			wo_len_q <= `RST_WO_LEN;
			ack_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			job_q <= job_d;
			ref_di_q <= ref_di_d;
			policy_q <= policy_d;
			size_q <= size_d;
			ok_q <= ok_d;
			xml_q <= xml_d;
			res_q <= res_d;
			idp_q <= idp_d;
			wo_len_q <= wo_len_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// Outputs from registers
	assign job_state = job_q;
	assign batch_ok = ok_q;
	assign xml_send_hold = xml_q;
	assign result_status = res_q;
	assign id_expect = idp_q;
	assign avs_readdata = rdata_q;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_abort_req;
		abort_p && job_q == JOB_RUN && !start;
	endsequence
	sequence s_aborted;
		job_state == JOB_ABORTED;
	endsequence

	chk_abort_stops_job: assert property (
		s_abort_req |=> s_aborted)
		else $error("abort did not end running job");
	chk_status_cleared: assert property (
		abort_stat_p |=> (result_status & ~$past(result_set)) == '0)
		else $error("result status not cleared");
	chk_xml_hold_follows: assert property (
		(fb_cmd.xml_hold || di_cmd.xml_hold) |=> xml_send_hold)
		else $error("result send not withheld");
	chk_dec_by_one: assert property (
		dec_ok && !inc_p && !start && batch_count != '0
		|=> batch_count == $past(batch_count) - BATCH_W'(1))
		else $error("decrement not by one");
	chk_dec_done_ignored: assert property (
		job_q == JOB_DONE && !inc_p && !start |=> $stable(batch_count))
		else $error("decrement after completion");
	chk_inc_by_one: assert property (
		inc_p && !dec_ok && !start && job_q != JOB_DONE &&
		batch_count != {BATCH_W{1'b1}}
		|=> batch_count == $past(batch_count) + BATCH_W'(1) &&
		batch_ok == $past(policy_q))
		else $error("increment or policy wrong");
	chk_bypass_moves: assert property (
		bypass_p && wo_len_q > ID_W'(1) && idp_q + ID_W'(1) < wo_len_q
		|=> id_expect == $past(idp_q) + ID_W'(1))
		else $error("identifier not bypassed");
	chk_held_once: assert property (
		fb_cmd.batch_inc [*2] |-> !rise[6])
		else $error("held item repeated");
	chk_one_wait: assert property (
		$rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait state");
endmodule
`default_nettype wire

/* pkg/cmd_decoder_consts.svh */
// Register offsets, field positions, reset values and codes of the decoder
`ifndef CMD_DECODER_CONSTS_SVH
`define CMD_DECODER_CONSTS_SVH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_BATCH 8'h08
`define REG_RESULT 8'h0c
`define REG_IDENT 8'h10
`define CTRL_START 0
`define CTRL_REF_DI 1
`define CTRL_POLICY 2
`define BATCH_SIZE_LSB 8
`define BATCH_OK_BIT 16
`define IDENT_LEN_LSB 8
`define RST_BATCH_SIZE 8'h01
`define RST_WO_LEN 4'h1
`define ABORT_LETTER 8'h41
`endif

/* pkg/cmd_decoder_pkg.sv */
// Types shared by the command decoder modules
package cmd_decoder_pkg;
	// One-bit command items from one source
	typedef struct packed {
		logic abort;
		logic abort_stat;
		logic xml_hold;
		logic batch_dec;
		logic batch_inc;
		logic id_bypass;
	} cmd_items_s;
	// Job progress
	typedef enum logic [1:0] {JOB_IDLE, JOB_RUN, JOB_DONE, JOB_ABORTED} job_state_e;
endpackage

/* design/rise_detect.sv */
// Rising edge detector for a vector of command levels
`timescale 1ns/10ps
`default_nettype none
module rise_detect #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Levels in, one-cycle pulses out
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] prev_q;
	logic [W-1:0] prev_d;

	// Pulse only where the level was low one cycle ago
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign rise[i] = level[i] & ~prev_q[i];
		end
	endgenerate

	// Next history
	always_comb begin
		prev_d = level;
	end

	// History register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end
endmodule
`default_nettype wire

/* design/batch_counter.sv */
// Batch counter with one-step increment and decrement
`timescale 1ns/10ps
`default_nettype none
module batch_counter #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic inc,
	input wire logic dec,
	input wire logic [W-1:0] size,
	// State
	output logic [W-1:0] count_q,
	output logic done
);
	logic [W-1:0] count_d;

	// Step by one, saturating at both ends; both together cancel
	always_comb begin
		count_d = count_q;
		if (clear) begin
			count_d = '0;
		end else if (inc && !dec && count_q != {W{1'b1}}) begin
			count_d = count_q + W'(1);
		end else if (dec && !inc && count_q != '0) begin
			count_d = count_q - W'(1);
		end
	end

	assign done = (size != '0) && (count_q >= size);

	// Counter register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule
`default_nettype wire

/* bench/cmd_source.sv */
// Model of the command sources: fieldbus master and digital inputs
`timescale 1ns/10ps
`default_nettype none
module cmd_source
	import cmd_decoder_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Command items
	output cmd_items_s fb_cmd,
	output logic [7:0] fb_abort_char,
	output cmd_items_s di_cmd
);
	// Idle sources drive no command
	initial begin
		fb_cmd = '0;
		di_cmd = '0;
		fb_abort_char = 8'h00;
	end
	// Set condition raises one item of one source
	task automatic set_item(input logic di, input int idx);
		@(posedge clk_sys);
		if (di) begin
			di_cmd[idx] <= 1'b1;
		end else begin
			fb_cmd[idx] <= 1'b1;
		end
	endtask
	// Reset condition clears every item
	task automatic clr_all();
		@(posedge clk_sys);
		fb_cmd <= '0;
		di_cmd <= '0;
		fb_abort_char <= 8'h00;
	endtask
	// Character form of the abort item
	task automatic abort_char();
		@(posedge clk_sys);
		fb_abort_char <= 8'h41;
	endtask
endmodule
`default_nettype wire

/* bench/input_command_decoder_tb.sv */
// Self-checking bench of the command item decoder
`timescale 1ns/10ps
`default_nettype none
`include "cmd_decoder_consts.svh"
module input_command_decoder_tb
	import cmd_decoder_pkg::*;
;
	localparam int ABT = 5, ABS = 4, XML = 3, DEC = 2, INC = 1, BYP = 0;
	logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, id_accept;
	logic [7:0] avs_address, fb_abort_char, result_set, batch_count;
	logic [7:0] result_status;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] id_expect;
	logic batch_ok, xml_send_hold;
	cmd_items_s fb_cmd, di_cmd;
	job_state_e job_state;
	int mismatches = 0, checked = 0;
	// Design under test
	input_command_decoder input_command_decoder_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.fb_cmd(fb_cmd), .fb_abort_char(fb_abort_char), .di_cmd(di_cmd),
		.result_set(result_set), .id_accept(id_accept),
		.job_state(job_state), .batch_count(batch_count),
		.batch_ok(batch_ok), .xml_send_hold(xml_send_hold),
		.result_status(result_status), .id_expect(id_expect));
	// Command sources
	cmd_source cmd_source_inst (.clk_sys(clk_sys), .fb_cmd(fb_cmd),
		.fb_abort_char(fb_abort_char), .di_cmd(di_cmd));
	// Verdict and end of run
	task automatic finish_test();
		if (mismatches == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Compare seen against expected
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// One Avalon-MM access, held until waitrequest is low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			mismatches++;
			finish_test();
		end
		// Read data is taken at the edge where waitrequest is seen low
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Raise one item for n+1 cycles, drop it and let the effect land
	task automatic act(input logic di, input int idx, input int n);
		cmd_source_inst.set_item(di, idx);
		repeat (n) @(posedge clk_sys);
		cmd_source_inst.clr_all();
		repeat (2) @(posedge clk_sys);
	endtask
	// Clock of 5 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{avs_read, avs_write, id_accept} = 3'h0;
		{avs_address, result_set, avs_writedata} = 48'h0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check("count", batch_count, 32'h0);
		bus(1'b1, `REG_BATCH, 32'h00000300);
		bus(1'b0, `REG_BATCH, 32'h0);
		check("batch", q, 32'h00000300);
		bus(1'b0, 8'h20, 32'h0);
		check("unmapped", q, 32'h0);
		bus(1'b1, `REG_CTRL, 32'h00000005);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("status", q, 32'h1);
		act(1'b0, INC, 4);
		check("count", batch_count, 32'h1);
		check("ok", batch_ok, 32'h1);
		act(1'b1, DEC, 1);
		check("count", batch_count, 32'h1);
		act(1'b0, DEC, 1);
		check("count", batch_count, 32'h0);
		repeat (3) act(1'b0, INC, 1);
		check("job", job_state, JOB_DONE);
		act(1'b0, DEC, 1);
		check("count", batch_count, 32'h3);
		result_set <= 8'h05;
		@(posedge clk_sys);
		result_set <= 8'h00;
		bus(1'b1, `REG_CTRL, 32'h00000005);
		check("results", result_status, 32'h5);
		act(1'b0, ABS, 1);
		check("job", job_state, JOB_ABORTED);
		check("results", result_status, 32'h0);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("status", q, 32'h3);
		bus(1'b1, `REG_CTRL, 32'h00000005);
		cmd_source_inst.abort_char();
		repeat (2) @(posedge clk_sys);
		check("job", job_state, JOB_ABORTED);
		cmd_source_inst.clr_all();
		bus(1'b1, `REG_CTRL, 32'h00000005);
		act(1'b1, ABT, 1);
		check("job", job_state, JOB_ABORTED);
		act(1'b1, XML, 4);
		cmd_source_inst.set_item(1'b1, XML);
		repeat (3) @(posedge clk_sys);
		check("hold", xml_send_hold, 32'h1);
		cmd_source_inst.clr_all();
		repeat (3) @(posedge clk_sys);
		check("hold", xml_send_hold, 32'h0);
		bus(1'b1, `REG_IDENT, 32'h00000300);
		repeat (2) act(1'b0, BYP, 1);
		check("ident", id_expect, 32'h2);
		act(1'b1, BYP, 1);
		check("ident", id_expect, 32'h0);
		id_accept <= 1'b1;
		@(posedge clk_sys);
		id_accept <= 1'b0;
		@(posedge clk_sys);
		check("ident", id_expect, 32'h1);
		// Digital inputs as job reference, policy low
		bus(1'b1, `REG_CTRL, 32'h00000003);
		act(1'b0, INC, 1);
		check("count", batch_count, 32'h1);
		check("ok", batch_ok, 32'h0);
		act(1'b0, DEC, 1);
		check("count", batch_count, 32'h1);
		act(1'b1, DEC, 1);
		check("count", batch_count, 32'h0);
		finish_test();
	end
endmodule
`default_nettype wire
